// [verilog/clpd_cfg.svh]
// Offsets, field positions, reset values and timing counts of the detector
`ifndef CLPD_CFG_SVH
`define CLPD_CFG_SVH

// Register byte offsets
`define CLPD_CTRL_OFS 12'h000
`define CLPD_LOW_OFS 12'h004
`define CLPD_HIGH_OFS 12'h008
`define CLPD_OVER_OFS 12'h00c
`define CLPD_START_DELAY_TIME_OFS 12'h010
`define CLPD_MAX_INRUSH_TIME_OFS 12'h014
`define CLPD_MIN_HOLD_TIME_OFS 12'h018
`define CLPD_STAT_OFS 12'h01c
`define CLPD_CNT_OFS 12'h020
`define CLPD_REC_PTR_OFS 12'h024
`define CLPD_REC_BASE_OFS 12'h040
`define CLPD_REC_LAST_OFS 12'h06c

// Control fields
`define CLPD_CTRL_CLR_ACT_BIT 0
`define CLPD_CTRL_CLR_BLK_BIT 1

// Thresholds in 0.01 x In units, times in 0.005 s ticks
`define CLPD_LOW_RST 16'h0014
`define CLPD_HIGH_RST 16'h0078
`define CLPD_OVER_RST 16'h00c8
`define CLPD_START_DELAY_TIME_RST 20'h007d0
`define CLPD_MAX_INRUSH_TIME_RST 20'h01770
`define CLPD_MIN_HOLD_TIME_RST 20'h00008

// Dropout ratio 97 percent
`define CLPD_HYST_NUM 7'd97
`define CLPD_HYST_DEN 7'd100

// Program cycle tick: 5 ms at 100 MHz
`define CLPD_TICK_MS 5
`define CLPD_CLK_MHZ 100
`define CLPD_TICK_CYC (`CLPD_TICK_MS * 1000 * `CLPD_CLK_MHZ)

`define CLPD_REC_DEPTH 12

`endif

// [verilog/clpd_pkg.sv]
// Types shared by the cold load pick-up detector
package clpd_pkg;

    typedef enum logic [2:0] {
        CLPD_NORMAL,
        CLPD_CURR_LOW,
        CLPD_OVERCURRENT,
        CLPD_ACTIVE,
        CLPD_BLOCKED
    } clpd_cond_t;

    typedef enum logic [1:0] {
        CLPD_ST_IDLE,
        CLPD_ST_HOLD,
        CLPD_ST_INRUSH,
        CLPD_ST_BLOCKED
    } clpd_fsm_t;

    typedef struct packed {
        logic [15:0] a;
        logic [15:0] b;
        logic [15:0] c;
    } clpd_phases_t;

    typedef struct packed {
        logic [15:0] low;
        logic [15:0] high;
        logic [15:0] over;
        logic [19:0] start_delay_time;
        logic [19:0] max_inrush_time;
        logic [19:0] min_hold_time;
    } clpd_set_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pslverr;
    } clpd_apb_rsp_t;

endpackage : clpd_pkg

// [verilog/clpd_top.sv]
// Cold load pick-up detector with APB settings and status
// How it works
// - Three fundamental phase magnitudes, each compared
// - Picked-up conditions drop out at 97 percent
// - One threshold set shared by all phases
// - Low condition when all phases below low
// - Inrush condition when all phases above high
// - Any phase over overcurrent releases at once
// - Activate after low persists for start delay
// - Inrush longer than max time releases output
// - No inrush: hold minimum time, then release
// - Inrush during hold switches to max timing
// - Inrush ending means finish remaining hold time, then release
// - Zero start delay activates in same evaluation
// - Block input sampled at each cycle start
// - Unblocked pick-up raises active, runs timers
// - Blocked pick-up raises only blocked indication
// - Later block resets output, normal release
// - Read-only five-state condition code
// - Settings change live without restart
// - Resettable counters of activations and blocks
// - Twelve-record ring, oldest overwritten
`timescale 1ns/1ps
`include "clpd_cfg.svh"

module clpd_top
    import clpd_pkg::*;
#(
    parameter int TICK_CYC = `CLPD_TICK_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire clpd_phases_t measured_magnitude,
    input wire logic block_in,
    output logic cold_load_active,
    output logic cold_load_blocked,
    output logic program_tick,
    output clpd_cond_t detector_condition_code
);

    typedef struct packed {
        logic [1:0] blk_sync;
        logic [31:0] tick_cnt;
        logic blk_smp;
        clpd_set_t set;
        clpd_fsm_t fsm;
        logic low_on;
        logic high_on;
        logic over_on;
        logic [19:0] tmr;
        logic [19:0] hold_tmr;
        logic ended;
        logic active;
        logic blocked;
        clpd_cond_t cond;
        logic [15:0] cnt_act;
        logic [15:0] cnt_blk;
        logic [3:0] rec_ptr;
        logic [31:0] prdata;
        logic tick;
    } clpd_state_t;

    clpd_state_t s_reg;
    clpd_state_t s_next;
    logic [31:0] rec_mem [0:`CLPD_REC_DEPTH-1];

    // Per-phase comparisons with 97 percent dropout level
    function automatic logic above(input logic [15:0] m,
                                   input logic [15:0] th,
                                   input logic was);
        logic [22:0] lhs;
        logic [22:0] rhs;
        lhs = 23'(m) * 23'(`CLPD_HYST_DEN);
        rhs = 23'(th) * 23'(`CLPD_HYST_NUM);
        above = was ? (lhs > rhs) : (m > th);
    endfunction : above

    function automatic logic below(input logic [15:0] m,
                                   input logic [15:0] th,
                                   input logic was);
        logic [22:0] lhs;
        logic [22:0] rhs;
        lhs = 23'(m) * 23'(`CLPD_HYST_DEN);
        rhs = 23'(th) * 23'(`CLPD_HYST_NUM);
        // Dropout when rising past 97 percent of setting
        below = was ? (lhs < rhs) : (m < th);
    endfunction : below

    logic wr_en;
    logic rd_en;
    logic rec_we;
    logic [31:0] rec_word;
    logic addr_ok;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    // Zero wait states; one cycle per access phase
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    // Address decode, records occupy twelve words
    always_comb begin
        addr_ok = 1'b0;
        case (paddr)
            `CLPD_CTRL_OFS, `CLPD_LOW_OFS, `CLPD_HIGH_OFS,
            `CLPD_OVER_OFS, `CLPD_START_DELAY_TIME_OFS, `CLPD_MAX_INRUSH_TIME_OFS,
            `CLPD_MIN_HOLD_TIME_OFS, `CLPD_STAT_OFS, `CLPD_CNT_OFS,
            `CLPD_REC_PTR_OFS: addr_ok = 1'b1;
            default: begin
                addr_ok = (paddr >= `CLPD_REC_BASE_OFS) &&
                          (paddr <= `CLPD_REC_LAST_OFS) &&
                          (paddr[1:0] == 2'h0);
            end
        endcase
    end

    // Detection, timers, bus registers in one next-state process
    always_comb begin
        logic lo_all;
        logic hi_all;
        logic ov_any;
        logic [19:0] tinc;
        logic [3:0] ridx;
        logic ev_act;
        logic ev_blk;
        lo_all = 1'b0;
        hi_all = 1'b0;
        ov_any = 1'b0;
        tinc = 20'h00000;
        ridx = 4'h0;
        ev_act = 1'b0;
        ev_blk = 1'b0;
        s_next = s_reg;
        rec_we = 1'b0;
        rec_word = 32'h0000_0000;
        s_next.tick = 1'b0;
        // Pin synchroniser, first stage only feeds second
        s_next.blk_sync = {s_reg.blk_sync[0], block_in};
        // Program cycle timebase
        if (s_reg.tick_cnt >= 32'(TICK_CYC - 1)) begin
            s_next.tick_cnt = 32'h0000_0000;
            s_next.tick = 1'b1;
        end else begin
            s_next.tick_cnt = s_reg.tick_cnt + 32'h0000_0001;
        end
        // Shared thresholds on every phase
        lo_all = below(measured_magnitude.a, s_reg.set.low, s_reg.low_on)
              && below(measured_magnitude.b, s_reg.set.low, s_reg.low_on)
              && below(measured_magnitude.c, s_reg.set.low,
                       s_reg.low_on);
        hi_all = above(measured_magnitude.a, s_reg.set.high, s_reg.high_on)
              && above(measured_magnitude.b, s_reg.set.high, s_reg.high_on)
              && above(measured_magnitude.c, s_reg.set.high,
                       s_reg.high_on);
        ov_any = above(measured_magnitude.a, s_reg.set.over, s_reg.over_on)
              || above(measured_magnitude.b, s_reg.set.over, s_reg.over_on)
              || above(measured_magnitude.c, s_reg.set.over,
                       s_reg.over_on);
        // Evaluation runs only at program-cycle ticks
        if (s_reg.tick) begin
            s_next.blk_smp = s_reg.blk_sync[1];
            s_next.low_on = lo_all;
            s_next.high_on = hi_all;
            s_next.over_on = ov_any;
            case (s_reg.fsm)
                CLPD_ST_IDLE: begin
                    tinc = lo_all ? s_reg.tmr + 20'h00001 : 20'h00000;
                    s_next.tmr = tinc;
                    // Zero delay passes on first low sample
                    if (lo_all && (tinc > s_reg.set.start_delay_time ||
                        s_reg.set.start_delay_time == 20'h00000)) begin
                        s_next.tmr = 20'h00000;
                        s_next.hold_tmr = 20'h00000;
                        s_next.ended = 1'b0;
                        if (s_next.blk_smp) begin
                            s_next.fsm = CLPD_ST_BLOCKED;
                            ev_blk = 1'b1;
                        end else begin
                            s_next.fsm = CLPD_ST_HOLD;
                            ev_act = 1'b1;
                        end
                    end
                end
                CLPD_ST_BLOCKED: begin
                    // No timers; indication lasts while low persists
                    if (!lo_all) begin
                        s_next.fsm = CLPD_ST_IDLE;
                    end
                end
                CLPD_ST_HOLD: begin
                    if (!lo_all) begin
                        s_next.hold_tmr = s_reg.hold_tmr + 20'h00001;
                    end
                    if (hi_all) begin
                        s_next.fsm = CLPD_ST_INRUSH;
                        s_next.tmr = 20'h00000;
                    end else if (!lo_all &&
                        s_next.hold_tmr >= s_reg.set.min_hold_time) begin
                        s_next.fsm = CLPD_ST_IDLE;
                        s_next.tmr = 20'h00000;
                    end
                end
                CLPD_ST_INRUSH: begin
                    s_next.hold_tmr = s_reg.hold_tmr + 20'h00001;
                    if (hi_all) begin
                        s_next.tmr = s_reg.tmr + 20'h00001;
                        if (s_next.tmr >= s_reg.set.max_inrush_time) begin
                            s_next.fsm = CLPD_ST_IDLE;
                            s_next.tmr = 20'h00000;
                        end
                    end else begin
                        // Start-up over; finish remaining hold time
                        s_next.ended = 1'b1;
                        s_next.fsm = CLPD_ST_HOLD;
                        s_next.tmr = 20'h00000;
                    end
                end
                default: s_next.fsm = CLPD_ST_IDLE;
            endcase
            // Overcurrent and late block override timing
            if (s_reg.fsm == CLPD_ST_HOLD || s_reg.fsm == CLPD_ST_INRUSH)
            begin
                if (ov_any) begin
                    s_next.fsm = CLPD_ST_IDLE;
                    s_next.tmr = 20'h00000;
                end else if (s_next.blk_smp) begin
                    s_next.fsm = CLPD_ST_IDLE;
                    s_next.tmr = 20'h00000;
                end
            end
            s_next.active = (s_next.fsm == CLPD_ST_HOLD) ||
                            (s_next.fsm == CLPD_ST_INRUSH);
            s_next.blocked = (s_next.fsm == CLPD_ST_BLOCKED);
            // Condition code priority: blocked, active, over, low
            if (s_next.blocked) begin
                s_next.cond = CLPD_BLOCKED;
            end else if (s_next.active) begin
                s_next.cond = CLPD_ACTIVE;
            end else if (ov_any) begin
                s_next.cond = CLPD_OVERCURRENT;
            end else if (lo_all) begin
                s_next.cond = CLPD_CURR_LOW;
            end else begin
                s_next.cond = CLPD_NORMAL;
            end
        end
        // Record ring, oldest slot overwritten
        if (ev_act || ev_blk) begin
            rec_we = 1'b1;
            rec_word = {ev_blk, 3'(s_reg.cond), 4'h0,
                        measured_magnitude.a[7:0],
                        measured_magnitude.b[7:0],
                        measured_magnitude.c[7:0]};
            s_next.rec_ptr = (s_reg.rec_ptr == 4'(`CLPD_REC_DEPTH - 1)) ?
                             4'h0 : s_reg.rec_ptr + 4'h1;
        end
        // Settings writable at any time, used next evaluation
        if (wr_en) begin
            case (paddr)
                `CLPD_LOW_OFS: s_next.set.low = pwdata[15:0];
                `CLPD_HIGH_OFS: s_next.set.high = pwdata[15:0];
                `CLPD_OVER_OFS: s_next.set.over = pwdata[15:0];
                `CLPD_START_DELAY_TIME_OFS: s_next.set.start_delay_time = pwdata[19:0];
                `CLPD_MAX_INRUSH_TIME_OFS: s_next.set.max_inrush_time = pwdata[19:0];
                `CLPD_MIN_HOLD_TIME_OFS: s_next.set.min_hold_time = pwdata[19:0];
                default: ;
            endcase
        end
        // Counters; an event in the clear cycle still counts
        if (wr_en && paddr == `CLPD_CTRL_OFS &&
            pwdata[`CLPD_CTRL_CLR_ACT_BIT]) begin
            s_next.cnt_act = 16'h0000;
        end
        if (wr_en && paddr == `CLPD_CTRL_OFS &&
            pwdata[`CLPD_CTRL_CLR_BLK_BIT]) begin
            s_next.cnt_blk = 16'h0000;
        end
        if (ev_act) begin
            s_next.cnt_act = (wr_en && paddr == `CLPD_CTRL_OFS &&
                pwdata[`CLPD_CTRL_CLR_ACT_BIT]) ? 16'h0001 :
                s_reg.cnt_act + 16'h0001;
        end
        if (ev_blk) begin
            s_next.cnt_blk = (wr_en && paddr == `CLPD_CTRL_OFS &&
                pwdata[`CLPD_CTRL_CLR_BLK_BIT]) ? 16'h0001 :
                s_reg.cnt_blk + 16'h0001;
        end
        // Read data captured in setup phase
        if (rd_en) begin
            ridx = 4'(paddr[5:2] - 4'h0);
            case (paddr)
                `CLPD_LOW_OFS: s_next.prdata = {16'h0000, s_reg.set.low};
                `CLPD_HIGH_OFS: s_next.prdata = {16'h0000, s_reg.set.high};
                `CLPD_OVER_OFS: s_next.prdata = {16'h0000, s_reg.set.over};
                `CLPD_START_DELAY_TIME_OFS: s_next.prdata = {12'h000, s_reg.set.start_delay_time};
                `CLPD_MAX_INRUSH_TIME_OFS: s_next.prdata = {12'h000, s_reg.set.max_inrush_time};
                `CLPD_MIN_HOLD_TIME_OFS: s_next.prdata = {12'h000, s_reg.set.min_hold_time};
                `CLPD_STAT_OFS: s_next.prdata = {24'h000000,
                    s_reg.blk_smp, s_reg.fsm, s_reg.blocked,
                    s_reg.active, 3'(s_reg.cond)};
                `CLPD_CNT_OFS: s_next.prdata = {s_reg.cnt_blk,
                                                s_reg.cnt_act};
                `CLPD_REC_PTR_OFS: s_next.prdata = {28'h0000000,
                                                    s_reg.rec_ptr};
                default: begin
                    if (paddr >= `CLPD_REC_BASE_OFS &&
                        paddr <= `CLPD_REC_LAST_OFS) begin
                        s_next.prdata = rec_mem[ridx];
                    end else begin
                        s_next.prdata = 32'h0000_0000;
                    end
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
            s_reg.set.low <= `CLPD_LOW_RST;
            s_reg.set.high <= `CLPD_HIGH_RST;
            s_reg.set.over <= `CLPD_OVER_RST;
            s_reg.set.start_delay_time <= `CLPD_START_DELAY_TIME_RST;
            s_reg.set.max_inrush_time <= `CLPD_MAX_INRUSH_TIME_RST;
            s_reg.set.min_hold_time <= `CLPD_MIN_HOLD_TIME_RST;
            s_reg.fsm <= CLPD_ST_IDLE;
            s_reg.cond <= CLPD_NORMAL;
        end else begin
            s_reg <= s_next;
        end
    end

    // Record storage, no reset needed for contents
    always_ff @(posedge pclk) begin
        if (rec_we) begin
            rec_mem[s_reg.rec_ptr] <= rec_word;
        end
    end

    assign prdata = s_reg.prdata;
    assign cold_load_active = s_reg.active;
    assign cold_load_blocked = s_reg.blocked;
    assign program_tick = s_reg.tick;
    assign detector_condition_code = s_reg.cond;

endmodule : clpd_top

// [sim/clpd_sva.sv]
// Port-level checker for the cold load pick-up detector
`timescale 1ns/1ps

module clpd_sva
    import clpd_pkg::*;
#(
    parameter int TICK_CYC = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire clpd_phases_t measured_magnitude,
    input wire logic block_in,
    input wire logic cold_load_active,
    input wire logic cold_load_blocked,
    input wire logic program_tick,
    input wire clpd_cond_t detector_condition_code
);
    logic [31:0] gap_reg;
    logic seen_reg;

    // Cycles since last tick; first tick only arms the period check
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_reg <= 32'h0;
            seen_reg <= 1'b0;
        end else begin
            gap_reg <= program_tick ? 32'h0 : gap_reg + 32'h1;
            seen_reg <= seen_reg | program_tick;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_access;
        psel && penable;
    endsequence
    // Outputs move only just after an evaluation
    sequence s_eval;
        $past(program_tick) || $past(program_tick, 2);
    endsequence

    property p_ready; 1'b1 |-> pready; endproperty
    property p_err_hi; s_access ##0 (paddr >= 12'h070) |-> pslverr; endproperty
    property p_err_lo;
        s_access ##0 (paddr <= 12'h024 && paddr[1:0] == 2'h0) |-> !pslverr;
    endproperty
    property p_err_idle; !penable |-> !pslverr; endproperty
    property p_rise; $rose(cold_load_active) |-> s_eval; endproperty
    property p_fall; $fell(cold_load_active) |-> s_eval; endproperty
    property p_blk_rise; $rose(cold_load_blocked) |-> s_eval; endproperty
    property p_excl; !(cold_load_active && cold_load_blocked); endproperty
    property p_cond_act;
        cold_load_active |-> detector_condition_code == CLPD_ACTIVE;
    endproperty
    property p_cond_blk;
        cold_load_blocked |-> detector_condition_code == CLPD_BLOCKED;
    endproperty
    property p_tick; program_tick && seen_reg |-> gap_reg == TICK_CYC - 1;
    endproperty
    property p_tick_pulse; program_tick |=> !program_tick; endproperty

    a_ready: assert property (p_ready) else $error("pready low");
    a_err_hi: assert property (p_err_hi) else $error("no error unmapped");
    a_err_lo: assert property (p_err_lo) else $error("error on mapped");
    a_err_idle: assert property (p_err_idle) else $error("error outside access");
    a_rise: assert property (p_rise) else $error("active rose off tick");
    a_fall: assert property (p_fall) else $error("active fell off tick");
    a_blk_rise: assert property (p_blk_rise) else $error("blocked off tick");
    a_excl: assert property (p_excl) else $error("active and blocked");
    a_cond_act: assert property (p_cond_act) else $error("code not active");
    a_cond_blk: assert property (p_cond_blk) else $error("code not blocked");
    a_tick: assert property (p_tick) else $error("tick period wrong");
    a_tick_pulse: assert property (p_tick_pulse) else $error("tick too long");
endmodule : clpd_sva

bind clpd_top clpd_sva #(.TICK_CYC(TICK_CYC)) u_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .measured_magnitude(measured_magnitude), .block_in(block_in),
    .cold_load_active(cold_load_active),
    .cold_load_blocked(cold_load_blocked), .program_tick(program_tick),
    .detector_condition_code(detector_condition_code)
);

// [sim/cold_load_pickup_detector_tb.sv]
// Self-checking bench for the cold load pick-up detector
`timescale 1ns/1ps
`include "clpd_cfg.svh"

module cold_load_pickup_detector_tb
    import clpd_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, block_in;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic act, blk, tick;
    clpd_phases_t ph;
    clpd_cond_t cond;
    int bad_count, total_checks, cyc;

    // Short tick keeps every timer scenario to a few hundred cycles
    clpd_top #(.TICK_CYC(4)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .measured_magnitude(ph),
        .block_in(block_in), .cold_load_active(act),
        .cold_load_blocked(blk), .program_tick(tick),
        .detector_condition_code(cond)
    );

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    // Hang guard, far beyond the expected run length
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            bad_count++;
            $display("MISMATCH %0t timeout", $time);
            summarize();
        end
    end

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
            input string what);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp,
            input string what);
        chk_word({31'h0, got}, {31'h0, exp}, what);
    endtask : chk_bit

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a,
            input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // pready high ends this wait; failing that, only the bench hang guard
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
            input logic exp_err);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk_word(q, exp, "read data");
        chk_bit(e, exp_err, "slave error");
    endtask : rd_chk

    task automatic set_in(input logic [15:0] a, input logic [15:0] b,
            input logic [15:0] c, input logic bv);
        @(posedge pclk);
        ph <= '{a, b, c};
        block_in <= bv;
    endtask : set_in

    // Wait n evaluations, then let the outputs settle
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge pclk);
            while (tick !== 1'b1) @(posedge pclk);
        end
        repeat (2) @(posedge pclk);
        #1;
    endtask : ticks

    initial begin
        logic [11:0] ofs [6];
        logic [31:0] dft [6];
        ofs = '{`CLPD_LOW_OFS, `CLPD_HIGH_OFS, `CLPD_OVER_OFS,
            `CLPD_START_DELAY_TIME_OFS, `CLPD_MAX_INRUSH_TIME_OFS, `CLPD_MIN_HOLD_TIME_OFS};
        dft = '{32'h14, 32'h78, 32'hc8, 32'h7d0, 32'h1770, 32'h8};
        presetn = 1'b0;
        {psel, penable, pwrite, block_in} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        ph = '{16'd50, 16'd50, 16'd50}; // Mid current, no early pick-up
        bad_count = 0;
        total_checks = 0;
        cyc = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // Defaults, unmapped access, idle code
        for (int i = 0; i < 6; i++) rd_chk(ofs[i], dft[i], 1'b0);
        wr(12'h070, 32'h1);
        rd_chk(12'h070, 32'h0, 1'b1);
        chk_word({29'h0, cond}, {29'h0, CLPD_NORMAL}, "reset code");
        // Live settings: zero start delay, short hold and inrush
        wr(`CLPD_START_DELAY_TIME_OFS, 32'h0);
        wr(`CLPD_MIN_HOLD_TIME_OFS, 32'h3);
        wr(`CLPD_MAX_INRUSH_TIME_OFS, 32'h4);
        set_in(16'd50, 16'd50, 16'd50, 1'b0);
        ticks(2);
        chk_bit(act, 1'b0, "mid current idle");
        set_in(16'd10, 16'd10, 16'd10, 1'b0);
        ticks(1);
        chk_bit(act, 1'b1, "zero delay active");
        chk_word({29'h0, cond}, {29'h0, CLPD_ACTIVE}, "active code");
        // Between thresholds: hold then release
        set_in(16'd50, 16'd50, 16'd50, 1'b0);
        ticks(1);
        chk_bit(act, 1'b1, "hold running");
        ticks(4);
        chk_bit(act, 1'b0, "hold expired");
        // One phase not low: no pick-up
        set_in(16'd10, 16'd10, 16'd30, 1'b0);
        ticks(2);
        chk_bit(act, 1'b0, "one phase high");
        // Start delay of two ticks needs three low evaluations
        wr(`CLPD_START_DELAY_TIME_OFS, 32'h2);
        set_in(16'd10, 16'd10, 16'd10, 1'b0);
        ticks(2);
        chk_bit(act, 1'b0, "start delay running");
        chk_word({29'h0, cond}, {29'h0, CLPD_CURR_LOW},
            "low code");
        ticks(1);
        chk_bit(act, 1'b1, "start delay done");
        // Inrush in hold outlasts hold, released by max timer
        set_in(16'd150, 16'd150, 16'd150, 1'b0);
        ticks(3);
        chk_bit(act, 1'b1, "inrush keeps active");
        ticks(3);
        chk_bit(act, 1'b0, "max inrush release");
        // Inrush ends early: hold time then release
        wr(`CLPD_MAX_INRUSH_TIME_OFS, 32'h14);
        set_in(16'd10, 16'd10, 16'd10, 1'b0);
        ticks(3);
        chk_bit(act, 1'b1, "re-armed before inrush");
        set_in(16'd150, 16'd150, 16'd150, 1'b0);
        ticks(2);
        chk_bit(act, 1'b1, "inrush short");
        set_in(16'd50, 16'd50, 16'd50, 1'b0);
        ticks(5);
        chk_bit(act, 1'b0, "start-up ended");
        // Overcurrent on one phase releases at once
        set_in(16'd10, 16'd10, 16'd10, 1'b0);
        ticks(3);
        chk_bit(act, 1'b1, "active before overcurrent");
        set_in(16'd250, 16'd10, 16'd10, 1'b0);
        ticks(1);
        chk_bit(act, 1'b0, "overcurrent release");
        chk_word({29'h0, cond}, {29'h0, CLPD_OVERCURRENT},
            "over code");
        // Late block; synchroniser delays it by one evaluation
        set_in(16'd10, 16'd10, 16'd10, 1'b0);
        ticks(3);
        chk_bit(act, 1'b1, "active before block");
        set_in(16'd50, 16'd50, 16'd50, 1'b1);
        ticks(2);
        chk_bit(act, 1'b0, "block resets active");
        // Pick-up while blocked: only blocked indication
        set_in(16'd10, 16'd10, 16'd10, 1'b1);
        ticks(4);
        chk_bit(act, 1'b0, "blocked no active");
        chk_bit(blk, 1'b1, "blocked shown");
        chk_word({29'h0, cond}, {29'h0, CLPD_BLOCKED}, "blocked code");
        // Counters: five activations, one block; read-only then cleared
        wr(`CLPD_CNT_OFS, 32'hffffffff);
        rd_chk(`CLPD_CNT_OFS, 32'h00010005, 1'b0);
        wr(`CLPD_CTRL_OFS, 32'h3);
        rd_chk(`CLPD_CNT_OFS, 32'h0, 1'b0);
        // Status word while blocked
        rd_chk(`CLPD_STAT_OFS, 32'hf4, 1'b0);
        // Records keep the code seen before the event
        rd_chk(`CLPD_REC_BASE_OFS, 32'h000a0a0a, 1'b0);
        rd_chk(12'h054, 32'h900a0a0a, 1'b0);
        rd_chk(`CLPD_REC_PTR_OFS, 32'h6, 1'b0);
        summarize();
    end
endmodule : cold_load_pickup_detector_tb
